// File: hdl/tsc_params.svh
// Offsets, field positions, reset values and counts of the start-up clock block
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH
`define TSC_A_CTRL 8'h00
`define TSC_A_CFG 8'h04
`define TSC_A_STAT 8'h08
`define TSC_A_CMD 8'h0C
`define TSC_B_CLKSEL 0
`define TSC_B_IOSTBL 2
`define TSC_B_SUSTAT 3
`define TSC_B_FSEL 4
`define TSC_B_MODE 0
`define TSC_B_SWOVR 3
`define TSC_B_MONEN 4
`define TSC_B_PWRTN 5
`define TSC_B_FLAG 0
`define TSC_B_IRQEN 1
`define TSC_B_FSAFE 2
`define TSC_B_WHOLD 3
`define TSC_B_FSM 8
`define TSC_B_SLEEP 0
`define TSC_B_WAKE 1
`define TSC_RST_CFG 6'h19
`define TSC_RST_CLKSEL 2'h0
`define TSC_RST_FSEL 3'h0
`define TSC_SEL_PRI 2'h0
`define TSC_SEL_SEC 2'h1
`define TSC_SEL_FAIL 2'h2
`define TSC_M_LPX 3'h0
`define TSC_M_MIDX 3'h1
`define TSC_M_HSX 3'h2
`define TSC_M_EXTCLK 3'h3
`define TSC_M_EXTRES 3'h4
`define TSC_M_INTRES 3'h5
`define TSC_STARTUP_CYC 1024
`define TSC_HOLD_EDG 8
`define TSC_MON_DIV 64
`define TSC_OKAY 2'h0
`define TSC_SLVERR 2'h2
`endif

// File: hdl/tsc_pkg.sv
// Types of the start-up clock block
package tsc_pkg;
   typedef enum logic [5:0] {
      ST_PWRT = 6'h01,
      ST_STARTUP = 6'h02,
      ST_WAIT_IRC = 6'h04,
      ST_HOLD = 6'h08,
      ST_RUN = 6'h10,
      ST_SLEEP = 6'h20
   } tsc_fsm_t;
   typedef enum logic [2:0] {
      SRC_PRIMARY = 3'h0,
      SRC_SECONDARY = 3'h1,
      SRC_IRC = 3'h2,
      SRC_IOSC = 3'h3,
      SRC_LOW = 3'h4
   } tsc_src_t;
endpackage : tsc_pkg

// File: hdl/tsc_mon_if.sv
// Signals between control and fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
interface tsc_mon_if;
   logic irc_rise;
   logic clk_fall;
   logic enable;
   logic fail;
   modport mon (input irc_rise, input clk_fall, input enable, output fail);
   modport ctl (output irc_rise, output clk_fall, output enable, input fail);
endinterface : tsc_mon_if
`default_nettype wire

// File: hdl/tsc_edge_sync.sv
// Two-flop pin synchroniser with edge detect
`timescale 1ns/1ps
`default_nettype none
module tsc_edge_sync #(
   parameter int W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } tsc_sync_st_t;
   tsc_sync_st_t st_reg;
   tsc_sync_st_t st_next;
   if (W < 1) begin : g_bad
      $error("tsc_edge_sync width below one");
   end
   always_comb begin
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign level = st_reg.s2;
   assign rise = st_reg.s2 & ~st_reg.s3;
   assign fall = ~st_reg.s2 & st_reg.s3;
endmodule : tsc_edge_sync
`default_nettype wire

// File: hdl/tsc_fail_mon.sv
// Fail-safe monitor: divided sample clock and monitor latch
`timescale 1ns/1ps
`default_nettype none
`include "tsc_params.svh"
module tsc_fail_mon #(
   parameter int DIV = `TSC_MON_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   tsc_mon_if.mon mon
);
   localparam int CW = $clog2(DIV);
   typedef struct packed {
      logic [CW-1:0] div;
      logic latch;
      logic fail;
   } tsc_mon_st_t;
   tsc_mon_st_t st_reg;
   tsc_mon_st_t st_next;
   if (DIV < 4 || (DIV & (DIV - 1)) != 0) begin : g_bad
      $error("tsc_fail_mon divider must be a power of two");
   end
   always_comb begin
      st_next = st_reg;
      st_next.fail = 1'b0;
      if (!mon.enable) begin
         st_next.div = '0;
         st_next.latch = 1'b1;
      end else if (mon.irc_rise) begin
         st_next.div = st_reg.div + 1'b1;
         if (st_reg.div == CW'(DIV / 2 - 1)) begin
            st_next.latch = 1'b0;
         end
         if (st_reg.div == CW'(DIV - 1) && !st_reg.latch && !mon.clk_fall) begin
            st_next.fail = 1'b1;
         end
      end
      if (mon.enable && mon.clk_fall) begin
         st_next.latch = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign mon.fail = st_reg.fail;
endmodule : tsc_fail_mon
`default_nettype wire

// File: hdl/tsc_top.sv
// Two-speed start-up and fail-safe clock control with AXI4-Lite registers
// Operation
// - With switchover enabled, run from internal RC until primary is stable.
// - Start on internal RC after power-up timer, wake, or any reset.
// - Every reset sets clock select to 00, primary oscillator.
// - Every reset clears frequency select, giving 31.25 kHz; software may raise.
// - Two-speed start-up only for the three crystal or resonator modes.
// - Nonzero frequency select uses oscillator output; stable bit clear until stable.
// - Count 1024 primary cycles, wait RC fall, set status, hold eight edges.
// - Clock select writes accepted before the start-up count ends.
// - Sleep during start-up aborts it and leaves status clear.
// - Monitor works only while its enable bit is set.
// - On failure set flag and move clock to internal oscillator.
// - Reset, sleep or control register write ends fail-safe.
// - Sample clock is internal RC divided by sixty-four.
// - Sample rise clears latch, clock fall sets; clear at sample fall fails.
// - Reset in fail-safe with crystal stays internal until count completes.
// - Monitor enable also enables two-speed start-up.
// - Reset in fail-safe with external source returns to it at once; reset reloads crystal mode 1, so the count runs first.
// - After fail-safe ends, keep monitoring; secondary failure switches and flags.
// - Failure forces clock select to 10 and clears the watchdog.
// - External or internal RC primary modes monitor at once.
// - No failure flagged during crystal start-up count.
// - Software clock switch releases the shared counter to the watchdog.
// - Watchdog held in reset while the start-up count runs.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_params.svh"
module tsc_top #(
   parameter int AW = 8,
   parameter int STARTUP_CYC = `TSC_STARTUP_CYC,
   parameter int HOLD_EDG = `TSC_HOLD_EDG,
   parameter int MON_DIV = `TSC_MON_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irc_clk_pin,
   input wire logic pri_clk_pin,
   input wire logic sec_clk_pin,
   input wire logic iosc_ready_pin,
   input wire logic pwrt_done,
   output logic [2:0] sys_clk_src,
   output logic exec_en,
   output logic wdt_hold,
   output logic wdt_clear,
   output logic osc_fail_irq
);
   localparam int CNTW = $clog2(STARTUP_CYC + HOLD_EDG);
   typedef struct packed {
      tsc_pkg::tsc_fsm_t fsm;
      logic [CNTW-1:0] cnt;
      logic [1:0] clk_sel;
      logic [2:0] fsel;
      logic su_stat;
      logic [5:0] cfg;
      logic flag;
      logic irq_en;
      logic fail_safe;
      logic wdt_hold;
      logic wdt_clear;
      tsc_pkg::tsc_src_t src;
      logic exec_en;
      logic irq;
      logic aw_full;
      logic [AW-1:0] awaddr;
      logic w_full;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tsc_top_st_t;
   tsc_top_st_t r;
   tsc_top_st_t n;
   logic [3:0] sync_lvl;
   logic [3:0] sync_rise;
   logic [3:0] sync_fall;
   logic [3:0] wsel;
   logic [3:0] rsel;
   logic [31:0] rd;
   logic wr_go;
   logic wen;
   logic wr_ctrl;
   logic sw_switch;
   logic sleep_cmd;
   logic wake_cmd;
   logic start;
   logic crystal;
   logic ts_en;
   logic fail_ev;
   tsc_pkg::tsc_src_t int_src;
   tsc_mon_if mon_if ();

   if (AW < 4 || STARTUP_CYC < 2 || HOLD_EDG < 1) begin : g_bad
      $error("tsc_top parameters out of range");
   end

   // One-hot register select, zero when unmapped
   function automatic logic [3:0] tsc_dec(input logic [AW-1:0] a);
      logic [AW-1:0] w;
      w = {a[AW-1:2], 2'b00};
      tsc_dec = '0;
      if (w == AW'(`TSC_A_CTRL)) tsc_dec[0] = 1'b1;
      if (w == AW'(`TSC_A_CFG)) tsc_dec[1] = 1'b1;
      if (w == AW'(`TSC_A_STAT)) tsc_dec[2] = 1'b1;
      if (w == AW'(`TSC_A_CMD)) tsc_dec[3] = 1'b1;
   endfunction : tsc_dec

   function automatic logic tsc_is_crystal(input logic [2:0] m);
      tsc_is_crystal = (m == `TSC_M_LPX) || (m == `TSC_M_MIDX) || (m == `TSC_M_HSX);
   endfunction : tsc_is_crystal

   tsc_edge_sync #(
      .W(4)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({iosc_ready_pin, sec_clk_pin, pri_clk_pin, irc_clk_pin}),
      .level(sync_lvl),
      .rise(sync_rise),
      .fall(sync_fall)
   );

   tsc_fail_mon #(
      .DIV(MON_DIV)
   ) u_mon (
      .aclk(aclk),
      .aresetn(aresetn),
      .mon(mon_if.mon)
   );

   assign mon_if.enable = r.cfg[`TSC_B_MONEN] && (r.fsm == tsc_pkg::ST_RUN)
      && !r.fail_safe
      && (r.src == tsc_pkg::SRC_PRIMARY || r.src == tsc_pkg::SRC_SECONDARY);
   assign mon_if.clk_fall = (r.src == tsc_pkg::SRC_SECONDARY) ? sync_fall[2] : sync_fall[1];
   assign mon_if.irc_rise = sync_rise[0];
   assign fail_ev = mon_if.fail && mon_if.enable;

   assign s_axi_awready = !r.aw_full && !r.bvalid;
   assign s_axi_wready = !r.w_full && !r.bvalid;
   assign s_axi_arready = !r.rvalid;

   always_comb begin
      n = r;
      start = 1'b0;
      crystal = tsc_is_crystal(r.cfg[`TSC_B_MODE +: 3]);
      ts_en = r.cfg[`TSC_B_SWOVR] || r.cfg[`TSC_B_MONEN];
      // Write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         n.aw_full = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.w_full = 1'b1;
         n.wdata = s_axi_wdata[7:0];
         n.wstrb0 = s_axi_wstrb[0];
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      wr_go = r.aw_full && r.w_full && !r.bvalid;
      wsel = tsc_dec(r.awaddr);
      if (wr_go) begin
         n.aw_full = 1'b0;
         n.w_full = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = (wsel == 4'h0) ? `TSC_SLVERR : `TSC_OKAY;
      end
      wen = wr_go && r.wstrb0;
      wr_ctrl = wen && wsel[0];
      sleep_cmd = wen && wsel[3] && r.wdata[`TSC_B_SLEEP];
      wake_cmd = wen && wsel[3] && r.wdata[`TSC_B_WAKE];
      sw_switch = wr_ctrl && (r.wdata[`TSC_B_CLKSEL +: 2] != `TSC_SEL_PRI);
      // Read path
      rsel = tsc_dec(s_axi_araddr);
      rd = '0;
      if (rsel[0]) begin
         rd[`TSC_B_CLKSEL +: 2] = r.clk_sel;
         rd[`TSC_B_IOSTBL] = (r.fsel != 3'h0) && sync_lvl[3];
         rd[`TSC_B_SUSTAT] = r.su_stat;
         rd[`TSC_B_FSEL +: 3] = r.fsel;
      end
      if (rsel[1]) begin
         rd[5:0] = r.cfg;
      end
      if (rsel[2]) begin
         rd[`TSC_B_FLAG] = r.flag;
         rd[`TSC_B_IRQEN] = r.irq_en;
         rd[`TSC_B_FSAFE] = r.fail_safe;
         rd[`TSC_B_WHOLD] = r.wdt_hold;
         rd[`TSC_B_FSM +: 6] = r.fsm;
      end
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !r.rvalid) begin
         n.rvalid = 1'b1;
         n.rdata = rd;
         n.rresp = (rsel == 4'h0) ? `TSC_SLVERR : `TSC_OKAY;
      end
      // Register writes
      if (wr_ctrl) begin
         n.clk_sel = r.wdata[`TSC_B_CLKSEL +: 2];
         n.fsel = r.wdata[`TSC_B_FSEL +: 3];
         n.fail_safe = 1'b0;
      end
      if (wen && wsel[1]) begin
         n.cfg = r.wdata[5:0];
      end
      if (wen && wsel[2]) begin
         if (r.wdata[`TSC_B_FLAG]) begin
            n.flag = 1'b0;
         end
         n.irq_en = r.wdata[`TSC_B_IRQEN];
      end
      n.wdt_clear = 1'b0;
      case (r.fsm)
         tsc_pkg::ST_PWRT: begin
            if (r.cfg[`TSC_B_PWRTN] || pwrt_done) begin
               start = 1'b1;
            end
         end
         tsc_pkg::ST_STARTUP: begin
            if (sw_switch) begin
               n.fsm = tsc_pkg::ST_RUN;
            end else if (sync_fall[1]) begin
               if (r.cnt == CNTW'(STARTUP_CYC - 1)) begin
                  n.fsm = tsc_pkg::ST_WAIT_IRC;
               end else begin
                  n.cnt = r.cnt + 1'b1;
               end
            end
         end
         tsc_pkg::ST_WAIT_IRC: begin
            if (sw_switch) begin
               n.fsm = tsc_pkg::ST_RUN;
            end else if (sync_fall[0]) begin
               n.su_stat = 1'b1;
               n.cnt = '0;
               n.fsm = tsc_pkg::ST_HOLD;
            end
         end
         tsc_pkg::ST_HOLD: begin
            if (sync_fall[1]) begin
               if (r.cnt == CNTW'(HOLD_EDG - 1)) begin
                  n.fsm = tsc_pkg::ST_RUN;
               end else begin
                  n.cnt = r.cnt + 1'b1;
               end
            end
         end
         tsc_pkg::ST_RUN: begin
            // Retry a crystal that is not engaged
            if (wr_ctrl && !sw_switch && crystal && !r.su_stat) begin
               start = 1'b1;
            end
         end
         tsc_pkg::ST_SLEEP: begin
            if (wake_cmd) begin
               start = 1'b1;
            end
         end
         default: begin
            n.fsm = tsc_pkg::ST_PWRT;
         end
      endcase
      if (start) begin
         n.cnt = '0;
         n.su_stat = !crystal;
         n.fsm = crystal ? tsc_pkg::ST_STARTUP : tsc_pkg::ST_RUN;
      end
      if (sleep_cmd && r.fsm != tsc_pkg::ST_SLEEP) begin
         n.fsm = tsc_pkg::ST_SLEEP;
         n.su_stat = 1'b0;
         n.fail_safe = 1'b0;
      end
      if (fail_ev) begin
         n.fail_safe = 1'b1;
         n.clk_sel = `TSC_SEL_FAIL;
         n.flag = 1'b1;
         n.wdt_clear = 1'b1;
      end
      int_src = (n.fsel != 3'h0) ? tsc_pkg::SRC_IOSC : tsc_pkg::SRC_IRC;
      n.wdt_hold = (n.fsm == tsc_pkg::ST_STARTUP);
      n.exec_en = 1'b0;
      n.src = tsc_pkg::SRC_LOW;
      case (n.fsm)
         tsc_pkg::ST_PWRT: begin
            n.src = int_src;
         end
         tsc_pkg::ST_STARTUP, tsc_pkg::ST_WAIT_IRC: begin
            if (ts_en) begin
               n.src = int_src;
               n.exec_en = 1'b1;
            end
         end
         tsc_pkg::ST_RUN: begin
            n.exec_en = 1'b1;
            case (n.clk_sel)
               `TSC_SEL_PRI: n.src = tsc_pkg::SRC_PRIMARY;
               `TSC_SEL_SEC: n.src = tsc_pkg::SRC_SECONDARY;
               default: n.src = int_src;
            endcase
            if (n.fail_safe) begin
               n.src = int_src;
            end
         end
         default: begin
            n.src = tsc_pkg::SRC_LOW;
         end
      endcase
      n.irq = n.flag && n.irq_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.fsm <= tsc_pkg::ST_PWRT;
         r.src <= tsc_pkg::SRC_IRC;
         r.cfg <= `TSC_RST_CFG;
         r.clk_sel <= `TSC_RST_CLKSEL;
         r.fsel <= `TSC_RST_FSEL;
      end else begin
         r <= n;
      end
   end

   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign sys_clk_src = r.src;
   assign exec_en = r.exec_en;
   assign wdt_hold = r.wdt_hold;
   assign wdt_clear = r.wdt_clear;
   assign osc_fail_irq = r.irq;
endmodule : tsc_top
`default_nettype wire

// File: sim/tsc_properties.sv
// Concurrent checks on the start-up clock block ports
`timescale 1ns/1ps
`default_nettype none
module tsc_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [2:0] sys_clk_src,
   input wire logic exec_en,
   input wire logic wdt_hold,
   input wire logic wdt_clear,
   input wire logic osc_fail_irq
);
   logic [2:0] wr_age_reg;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Cycles since the last accepted register write
   always_ff @(posedge aclk) begin
      if (!aresetn || (s_axi_wvalid && s_axi_wready)) begin
         wr_age_reg <= 3'h0;
      end else if (wr_age_reg != 3'h7) begin
         wr_age_reg <= wr_age_reg + 3'h1;
      end
   end

   a_reset_to_irc: assert property (
      $rose(aresetn) |-> sys_clk_src == 3'h2 && !exec_en && !wdt_hold)
      else $error("outputs not at start-up values after reset");
   a_clear_one_cycle: assert property (
      wdt_clear |=> !wdt_clear)
      else $error("watchdog clear longer than one cycle");
   a_fail_to_internal: assert property (
      wdt_clear |-> ##[0:1] (sys_clk_src == 3'h2 || sys_clk_src == 3'h3))
      else $error("failure did not move clock to internal source");
   a_no_fail_in_count: assert property (
      wdt_hold |-> !wdt_clear)
      else $error("failure flagged during start-up count");
   a_hold_not_primary: assert property (
      wdt_hold |-> sys_clk_src != 3'h0)
      else $error("primary selected while start-up count runs");
   a_hold_release: assert property (
      $fell(wdt_hold) |-> sys_clk_src != 3'h0)
      else $error("primary selected right at end of count");
   a_flag_sticky: assert property (
      $fell(osc_fail_irq) |-> wr_age_reg < 3'h5)
      else $error("fail interrupt dropped without a register write");
   a_irq_from_fail: assert property (
      $rose(osc_fail_irq) |-> wdt_clear || $past(wdt_clear) || wr_age_reg < 3'h5)
      else $error("fail interrupt rose without failure or write");

   c_failure: cover property (wdt_clear);
   c_count_end: cover property ($fell(wdt_hold));
   c_held_low: cover property (sys_clk_src == 3'h4);
   c_irq_clear: cover property ($fell(osc_fail_irq));
endmodule : tsc_properties

bind tsc_top tsc_properties chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .sys_clk_src(sys_clk_src), .exec_en(exec_en),
   .wdt_hold(wdt_hold), .wdt_clear(wdt_clear), .osc_fail_irq(osc_fail_irq)
);
`default_nettype wire

// File: sim/tsc_osc_model.sv
// Oscillator pin model: primary crystal, also reused for RC and secondary
`timescale 1ns/1ps
`default_nettype none
module tsc_osc_model (
   input wire logic aclk,
   input wire logic run,
   input wire logic [3:0] half,
   output logic clk
);
   logic [3:0] cnt;

   initial begin
      clk = 1'h0;
      cnt = 4'h0;
   end

   // A dead oscillator stands still where it stopped
   always @(posedge aclk) begin
      if (run) begin
         if (cnt >= half - 4'h1) begin
            cnt <= 4'h0;
            clk <= ~clk;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : tsc_osc_model
`default_nettype wire

// File: sim/tsc_top_tb.sv
// Self-checking bench for the start-up clock block
`timescale 1ns/1ps
`default_nettype none
`include "tsc_params.svh"
module tsc_top_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
   logic [3:0] s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic irc_clk_pin, pri_clk_pin, sec_clk_pin, iosc_ready_pin, pwrt_done;
   logic [2:0] sys_clk_src;
   logic exec_en, wdt_hold, wdt_clear, osc_fail_irq, pri_run, sec_run;
   logic [3:0] pri_half;
   int error_cnt, cmp_count;

   tsc_top #(.STARTUP_CYC(4), .HOLD_EDG(2), .MON_DIV(8)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .irc_clk_pin, .pri_clk_pin, .sec_clk_pin, .iosc_ready_pin, .pwrt_done,
      .sys_clk_src, .exec_en, .wdt_hold, .wdt_clear, .osc_fail_irq
   );
   tsc_osc_model pri_u (.aclk, .run(pri_run), .half(pri_half), .clk(pri_clk_pin));
   tsc_osc_model irc_u (.aclk, .run(1'h1), .half(4'h4), .clk(irc_clk_pin));
   tsc_osc_model sec_u (.aclk, .run(sec_run), .half(4'h3), .clk(sec_clk_pin));

   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end

   task finish_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   task tmo(input string n);
      error_cnt++;
      $display("MISMATCH %s exp done got timeout", n);
      finish_test();
   endtask : tmo

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk

   // Wait for hold (0), failure pulse (1) or a clock source (2)
   task wt(input int k, input logic [2:0] v);
      for (int i = 0; i < 600; i++) begin
         @(posedge aclk);
         if ((k == 0 && wdt_hold === 1'h1) || (k == 1 && wdt_clear === 1'h1)
             || (k == 2 && sys_clk_src === v)) begin
            return;
         end
      end
      tmo("wait");
   endtask : wt

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            brsp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            return;
         end
      end
      tmo("write");
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            rdat = s_axi_rdata;
            rrsp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            return;
         end
      end
      tmo("read");
   endtask : rd

   task rst(input int n);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (n) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
   endtask : rst

   task t_reset();
      chk("src", 32'h2, 32'(sys_clk_src));
      chk("exec", 32'h0, 32'(exec_en));
      rd(`TSC_A_CTRL);
      chk("clk_sel", 32'h0, rdat & 32'h3);
      chk("freq_sel", 32'h0, rdat & 32'h70);
      s_axi_wstrb <= 4'he;
      wr(`TSC_A_CFG, 32'h0);
      s_axi_wstrb <= 4'hf;
      chk("wr_resp", 32'h0, 32'(brsp));
      rd(`TSC_A_CFG);
      chk("cfg", 32'h19, rdat);
      rd(`TSC_A_STAT);
      chk("fsm", 32'h1, 32'(rdat[13:8]));
      rd(8'h10);
      chk("unmapped_resp", 32'h2, 32'(rrsp));
      wr(8'h10, 32'h0);
      chk("unmapped_wr", 32'h2, 32'(brsp));
      $display("t_reset done");
   endtask : t_reset

   task t_start();
      logic sl;
      sl = 1'h0;
      pwrt_done <= 1'h1;
      wt(0, 3'h0);
      chk("src_cnt", 32'h2, 32'(sys_clk_src));
      chk("exec_cnt", 32'h1, 32'(exec_en));
      for (int i = 0; i < 300 && sys_clk_src !== 3'h0; i++) begin
         @(posedge aclk);
         if (sys_clk_src === 3'h4) sl = 1'h1;
      end
      chk("src_run", 32'h0, 32'(sys_clk_src));
      chk("held_low", 32'h1, 32'(sl));
      chk("hold_off", 32'h0, 32'(wdt_hold));
      rd(`TSC_A_CTRL);
      chk("status", 32'h8, rdat & 32'h8);
      $display("t_start done");
   endtask : t_start

   task t_fail();
      wr(`TSC_A_STAT, 32'h2);
      pri_half <= 4'h3;
      pri_run <= 1'h0;
      wt(1, 3'h0);
      @(posedge aclk);
      chk("src_fail", 32'h2, 32'(sys_clk_src));
      chk("irq", 32'h1, 32'(osc_fail_irq));
      rd(`TSC_A_CTRL);
      chk("sel_fail", 32'h2, rdat & 32'h3);
      rd(`TSC_A_STAT);
      chk("stat_fail", 32'h7, rdat & 32'h7);
      pri_run <= 1'h1;
      wr(`TSC_A_STAT, 32'h3);
      rd(`TSC_A_STAT);
      chk("flag_clr", 32'h6, rdat & 32'h7);
      wr(`TSC_A_CTRL, 32'h12);
      rd(`TSC_A_STAT);
      chk("fsafe_off", 32'h2, rdat & 32'h7);
      chk("src_iosc", 32'h3, 32'(sys_clk_src));
      rd(`TSC_A_CTRL);
      chk("unstable", 32'h0, rdat & 32'h4);
      iosc_ready_pin <= 1'h1;
      repeat (4) @(posedge aclk);
      rd(`TSC_A_CTRL);
      chk("stable", 32'h4, rdat & 32'h4);
      $display("t_fail done");
   endtask : t_fail

   task t_sec();
      wr(`TSC_A_CTRL, 32'h11);
      wt(2, 3'h1);
      repeat (150) @(posedge aclk);
      chk("sec_ok", 32'h0, 32'(osc_fail_irq));
      sec_run <= 1'h0;
      wt(1, 3'h0);
      @(posedge aclk);
      chk("src_secf", 32'h3, 32'(sys_clk_src));
      chk("irq_sec", 32'h1, 32'(osc_fail_irq));
      sec_run <= 1'h1;
      $display("t_sec done");
   endtask : t_sec

   task t_sleep();
      rst(3);
      wt(0, 3'h0);
      chk("src_fs_rst", 32'h2, 32'(sys_clk_src));
      wr(`TSC_A_CMD, 32'h1);
      rd(`TSC_A_STAT);
      chk("fsm_sleep", 32'h20, 32'(rdat[13:8]));
      chk("fsafe_rst", 32'h0, rdat & 32'h4);
      rd(`TSC_A_CTRL);
      chk("ctrl_sleep", 32'h0, rdat & 32'h7b);
      wr(`TSC_A_CFG, 32'h13);
      wr(`TSC_A_CMD, 32'h2);
      wt(2, 3'h0);
      chk("no_count", 32'h0, 32'(wdt_hold));
      rd(`TSC_A_CTRL);
      chk("status_ext", 32'h8, rdat & 32'h8);
      pri_run <= 1'h0;
      wt(1, 3'h0);
      wr(`TSC_A_CFG, 32'h3);
      wr(`TSC_A_CMD, 32'h1);
      wr(`TSC_A_CMD, 32'h2);
      wr(`TSC_A_STAT, 32'h3);
      wr(`TSC_A_CTRL, 32'h0);
      wt(2, 3'h0);
      repeat (200) @(posedge aclk);
      rd(`TSC_A_STAT);
      chk("mon_off", 32'h0, rdat & 32'h1);
      pri_run <= 1'h1;
      $display("t_sleep done");
   endtask : t_sleep

   task t_abort();
      wr(`TSC_A_CFG, 32'h11);
      wr(`TSC_A_CMD, 32'h1);
      wr(`TSC_A_CMD, 32'h2);
      wt(0, 3'h0);
      chk("src_mon", 32'h2, 32'(sys_clk_src));
      chk("exec_mon", 32'h1, 32'(exec_en));
      wr(`TSC_A_CTRL, 32'h1);
      repeat (2) @(posedge aclk);
      chk("wdt_free", 32'h0, 32'(wdt_hold));
      chk("src_sw", 32'h1, 32'(sys_clk_src));
      $display("t_abort done");
   endtask : t_abort

   initial begin
      aresetn = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_awprot = 3'h2;
      s_axi_arprot = 3'h2;
      {iosc_ready_pin, pwrt_done} = 2'h0;
      {pri_run, sec_run} = 2'h3;
      pri_half = 4'h5;
      error_cnt = 0;
      cmp_count = 0;
      rst(16);
      t_reset();
      t_start();
      t_fail();
      t_sec();
      t_sleep();
      t_abort();
      finish_test();
   end
endmodule : tsc_top_tb
`default_nettype wire
